// File: include/atp_pkg.sv
// Constants and types for the timer flag, clock select and prescaler block.
// Assumes an AXI4-Lite register bus with 32-bit data and an 8-bit byte address.
`default_nettype none
package atp_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_ASYNC = 8'h08;
  localparam logic [7:0] OFS_GTC = 8'h0C;
  localparam logic [7:0] OFS_CLKSEL = 8'h10;
  localparam logic [7:0] OFS_CMP = 8'h14;
  localparam logic [7:0] OFS_COUNT = 8'h18;
  localparam logic [7:0] OFS_MODE = 8'h1C;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_CMP = 1;
  localparam int BIT_OVF = 0;
  localparam int BIT_ASYNC_SEL = 0;
  localparam int BIT_EXT_SEL = 1;
  localparam int BIT_PSR = 1;
  localparam int BIT_TSM = 7;
  localparam int BIT_UPDOWN = 0;
  // ----------------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------------
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [7:0] COUNT_TOP = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam int PRESC_W = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Crystal frequency the oscillator is built for, in hertz.
  localparam int XTAL_HZ = 32768;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam logic [2:0] CS_DIV1024 = 3'h7;

  // ----------------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [1:0] flags;
    logic [1:0] mask;
    logic async_sel;
    logic ext_sel;
    logic psr;
    logic timer_sync_hold;
    logic [2:0] clk_sel;
    logic [7:0] cmp;
    logic [7:0] cnt;
    logic updown;
    logic dir_down;
    logic [9:0] presc;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic [1:0] evt_p1;
    logic [1:0] evt_p2;
    logic ack_p1;
    logic ack_p2;
    logic cmp_irq;
    logic ovf_irq;
    logic osc_en;
    logic ext_clk;
  } atp_state_s;
endpackage
`default_nettype wire

// File: verilog/atp_timer.sv
// Interrupt flags, clock source choice and prescaler of an 8-bit timer.
// Assumes one 25 MHz clock, a synchronous crystal pin sample and an AXI4-Lite master.
//
// Function
// - Compare flag sets when counter equals compare value.
// - Compare flag clears when the compare vector executes.
// - Writing one to the compare flag clears it.
// - Compare interrupt requested only when global enable, mask bit and flag set.
// - Overflow flag sets when the counter overflows.
// - Overflow flag clears when the overflow vector executes.
// - Writing one to the overflow flag clears it.
// - Overflow interrupt requested only when global enable, mask bit and flag set.
// - In up-down mode overflow flag sets on direction change at zero.
// - Without async select the timer source is the I/O clock.
// - Async select clocks the timer from crystal oscillator or crystal pin.
// - Async select without external select enables the crystal oscillator.
// - Async and external select take an external clock on the crystal pin.
// - Clock choices: stop, undivided, or divided by 8,32,64,128,256,1024.
// - While prescaler reset request is one, the prescaler is reset.
// - Synchronous mode clears the reset request right after the reset.
// - Async mode keeps the request one until reset done in timer domain.
// - Sync hold bit set keeps the reset request and prescaler reset.
// - Flag bits 7 to 2 read zero; all flags reset to zero.
// - Mask bit 1 enables compare, bit 0 overflow; both reset zero.
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module atp_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor side
  input wire logic global_irq_enable,
  input wire logic compare_vector_ack,
  input wire logic overflow_vector_ack,
  output logic compare_irq,
  output logic overflow_irq,
  // Crystal pins
  input wire logic crystal_input_pin,
  output logic crystal_osc_enable,
  output logic external_clock_mode
);

  atp_pkg::atp_state_s s;
  atp_pkg::atp_state_s n;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == atp_pkg::OFS_FLAGS) || (a == atp_pkg::OFS_MASK) ||
      (a == atp_pkg::OFS_ASYNC) || (a == atp_pkg::OFS_GTC) ||
      (a == atp_pkg::OFS_CLKSEL) || (a == atp_pkg::OFS_CMP) ||
      (a == atp_pkg::OFS_COUNT) || (a == atp_pkg::OFS_MODE);
  endfunction

  // Mask of prescaler bits that must all be one for a divided tick.
  function automatic logic [9:0] div_mask(input logic [2:0] sel);
    unique case (sel)
      atp_pkg::CS_DIV8: div_mask = 10'h007;
      atp_pkg::CS_DIV32: div_mask = 10'h01F;
      atp_pkg::CS_DIV64: div_mask = 10'h03F;
      atp_pkg::CS_DIV128: div_mask = 10'h07F;
      atp_pkg::CS_DIV256: div_mask = 10'h0FF;
      atp_pkg::CS_DIV1024: div_mask = 10'h3FF;
      default: div_mask = 10'h000;
    endcase
  endfunction

  logic wr_fire;
  logic src_tick;
  logic tick;
  logic [1:0] ev_raw;
  logic [1:0] ev_apply;
  logic [1:0] flag_w1c;
  logic psr_wr_one;
  logic psr_clear;
  logic [7:0] cnt_step;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------------
  // Timer source, prescaler and counter
  // ----------------------------------------------------------------------
  always_comb begin
    // Crystal edge only counts in async mode; otherwise every I/O clock cycle.
    src_tick = s.async_sel ? (s.pin_s2 & ~s.pin_s3) : 1'b1;
    if (s.clk_sel == atp_pkg::CS_STOP) begin
      tick = 1'b0;
    end else if (s.clk_sel == atp_pkg::CS_DIV1) begin
      tick = src_tick;
    end else begin
      tick = src_tick && !s.psr &&
        ((s.presc & div_mask(s.clk_sel)) == div_mask(s.clk_sel));
    end
    ev_raw = 2'h0;
    cnt_step = s.cnt;
    if (tick) begin
      if (s.updown) begin
        if (!s.dir_down && s.cnt == atp_pkg::COUNT_TOP) begin
          cnt_step = s.cnt - 8'h01;
        end else if (s.dir_down && s.cnt == atp_pkg::COUNT_BOTTOM) begin
          cnt_step = s.cnt + 8'h01;
          ev_raw[atp_pkg::BIT_OVF] = 1'b1;
        end else begin
          cnt_step = s.dir_down ? s.cnt - 8'h01 : s.cnt + 8'h01;
        end
      end else begin
        cnt_step = s.cnt + 8'h01;
        ev_raw[atp_pkg::BIT_OVF] = (s.cnt == atp_pkg::COUNT_TOP);
      end
      ev_raw[atp_pkg::BIT_CMP] = (cnt_step == s.cmp);
    end
    ev_apply = s.async_sel ? s.evt_p2 : ev_raw;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = s;
    rd_word = 32'h0000_0000;
    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && s.aw_rdy) begin
      n.aw_have = 1'b1;
      n.aw_rdy = 1'b0;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.w_rdy) begin
      n.w_have = 1'b1;
      n.w_rdy = 1'b0;
      n.w_data = s_axi_wdata[7:0];
      n.w_strb0 = s_axi_wstrb[0];
    end
    wr_fire = s.aw_have && s.w_have && !s.bvalid;
    flag_w1c = 2'h0;
    psr_wr_one = 1'b0;
    if (wr_fire) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = is_mapped(s.aw_addr) ? atp_pkg::RESP_OKAY : atp_pkg::RESP_SLVERR;
      if (s.w_strb0) begin
        unique case (s.aw_addr)
          atp_pkg::OFS_FLAGS: flag_w1c = s.w_data[1:0];
          atp_pkg::OFS_MASK: n.mask = s.w_data[1:0];
          atp_pkg::OFS_ASYNC: begin
            n.async_sel = s.w_data[atp_pkg::BIT_ASYNC_SEL];
            n.ext_sel = s.w_data[atp_pkg::BIT_EXT_SEL];
          end
          atp_pkg::OFS_GTC: begin
            n.timer_sync_hold = s.w_data[atp_pkg::BIT_TSM];
            psr_wr_one = s.w_data[atp_pkg::BIT_PSR];
          end
          atp_pkg::OFS_CLKSEL: n.clk_sel = s.w_data[2:0];
          atp_pkg::OFS_CMP: n.cmp = s.w_data;
          atp_pkg::OFS_MODE: n.updown = s.w_data[atp_pkg::BIT_UPDOWN];
          default: ;
        endcase
      end
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.aw_rdy = 1'b1;
      n.w_rdy = 1'b1;
    end
    // Read channel.
    if (s_axi_arvalid && s.ar_rdy) begin
      unique case (s_axi_araddr)
        atp_pkg::OFS_FLAGS: rd_word = {30'h0, s.flags};
        atp_pkg::OFS_MASK: rd_word = {30'h0, s.mask};
        atp_pkg::OFS_ASYNC: rd_word = {30'h0, s.ext_sel, s.async_sel};
        atp_pkg::OFS_GTC: rd_word = {24'h0, s.timer_sync_hold, 5'h0, s.psr, 1'b0};
        atp_pkg::OFS_CLKSEL: rd_word = {29'h0, s.clk_sel};
        atp_pkg::OFS_CMP: rd_word = {24'h0, s.cmp};
        atp_pkg::OFS_COUNT: rd_word = {24'h0, s.cnt};
        atp_pkg::OFS_MODE: rd_word = {30'h0, s.dir_down, s.updown};
        default: rd_word = 32'h0000_0000;
      endcase
      n.rdata = rd_word;
      n.rresp = is_mapped(s_axi_araddr) ? atp_pkg::RESP_OKAY : atp_pkg::RESP_SLVERR;
      n.rvalid = 1'b1;
      n.ar_rdy = 1'b0;
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.ar_rdy = 1'b1;
    end

    // Crystal pin synchroniser and event pipeline.
    n.pin_s1 = crystal_input_pin;
    n.pin_s2 = s.pin_s1;
    n.pin_s3 = s.pin_s2;
    n.evt_p1 = ev_raw;
    n.evt_p2 = s.evt_p1;

    // Counter, up-down direction, prescaler and its reset request.
    n.cnt = cnt_step;
    if (tick && s.updown) begin
      if (!s.dir_down && s.cnt == atp_pkg::COUNT_TOP) begin
        n.dir_down = 1'b1;
      end else if (s.dir_down && s.cnt == atp_pkg::COUNT_BOTTOM) begin
        n.dir_down = 1'b0;
      end
    end else if (!s.updown) begin
      n.dir_down = 1'b0;
    end
    if (s.psr && (!s.async_sel || src_tick)) begin
      n.presc = 10'h000;
    end else if (src_tick) begin
      n.presc = s.presc + 10'h001;
    end
    n.ack_p1 = s.psr && s.async_sel && src_tick && !s.timer_sync_hold;
    n.ack_p2 = s.ack_p1;
    psr_clear = !s.timer_sync_hold && (s.async_sel ? s.ack_p2 : s.psr);
    if (psr_wr_one) begin
      n.psr = 1'b1;
    end else if (psr_clear) begin
      n.psr = 1'b0;
    end

    // Flags: a set event wins over any clear in the same cycle.
    n.flags[atp_pkg::BIT_CMP] = ev_apply[atp_pkg::BIT_CMP] ||
      (s.flags[atp_pkg::BIT_CMP] && !flag_w1c[atp_pkg::BIT_CMP] && !compare_vector_ack);
    n.flags[atp_pkg::BIT_OVF] = ev_apply[atp_pkg::BIT_OVF] ||
      (s.flags[atp_pkg::BIT_OVF] && !flag_w1c[atp_pkg::BIT_OVF] && !overflow_vector_ack);
    n.cmp_irq = global_irq_enable && n.mask[atp_pkg::BIT_CMP] &&
      n.flags[atp_pkg::BIT_CMP];
    n.ovf_irq = global_irq_enable && n.mask[atp_pkg::BIT_OVF] &&
      n.flags[atp_pkg::BIT_OVF];
    n.osc_en = n.async_sel && !n.ext_sel;
    n.ext_clk = n.async_sel && n.ext_sel;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.aw_rdy <= 1'b1;
      s.w_rdy <= 1'b1;
      s.ar_rdy <= 1'b1;
      s.flags <= atp_pkg::FLAGS_RST;
      s.mask <= atp_pkg::MASK_RST;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = s.aw_rdy;
  assign s_axi_wready = s.w_rdy;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.ar_rdy;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign compare_irq = s.cmp_irq;
  assign overflow_irq = s.ovf_irq;
  assign crystal_osc_enable = s.osc_en;
  assign external_clock_mode = s.ext_clk;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_cmp_irq_gate: assert property (@(posedge clock) disable iff (rst)
    compare_irq |-> (s.flags[1] && s.mask[1] && $past(global_irq_enable)))
    else $error("compare interrupt without flag, mask or global enable");
  chk_ovf_irq_gate: assert property (@(posedge clock) disable iff (rst)
    overflow_irq == (s.flags[0] && s.mask[0] && $past(global_irq_enable)))
    else $error("overflow interrupt does not follow flag, mask and global enable");
  chk_w1c_compare: assert property (@(posedge clock) disable iff (rst)
    (wr_fire && s.w_strb0 && s.aw_addr == 8'h00 && s.w_data[1] && !ev_apply[1])
    |=> !s.flags[1])
    else $error("compare flag not cleared by write of one");
  chk_zero_keeps: assert property (@(posedge clock) disable iff (rst)
    (wr_fire && s.aw_addr == 8'h00 && !s.w_data[0] && s.flags[0] && !overflow_vector_ack)
    |=> s.flags[0])
    else $error("overflow flag lost on write of zero");
  chk_vector_clear: assert property (@(posedge clock) disable iff (rst)
    (overflow_vector_ack && !ev_apply[0]) |=> !s.flags[0])
    else $error("overflow flag not cleared by vector");
  chk_sync_psr: assert property (@(posedge clock) disable iff (rst)
    (!s.async_sel && s.psr && !s.timer_sync_hold && !psr_wr_one) |=> !s.psr && s.presc == 10'h000)
    else $error("prescaler reset request not cleared in sync mode");
  chk_tsm_hold: assert property (@(posedge clock) disable iff (rst)
    (s.psr && s.timer_sync_hold) |=> s.psr)
    else $error("reset request cleared while sync hold set");
  chk_stop_holds: assert property (@(posedge clock) disable iff (rst)
    (s.clk_sel == 3'h0) |=> (s.cnt == $past(s.cnt)))
    else $error("counter moved while stopped");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    s.rvalid |-> (s.rdata[31:8] == 24'h000000))
    else $error("reserved read bits not zero");
  chk_mask_write: assert property (@(posedge clock) disable iff (rst)
    (wr_fire && s.w_strb0 && s.aw_addr == atp_pkg::OFS_MASK) |=> (s.mask == s.w_data[1:0]))
    else $error("mask register not written");
  chk_strb_ignore: assert property (@(posedge clock) disable iff (rst)
    (wr_fire && !s.w_strb0) |=> (s.mask == $past(s.mask)))
    else $error("mask changed by a write without strobe");
  chk_w1c_overflow: assert property (@(posedge clock) disable iff (rst)
    (wr_fire && s.w_strb0 && s.aw_addr == atp_pkg::OFS_FLAGS && s.w_data[0] && !ev_apply[0])
    |=> !s.flags[0])
    else $error("overflow flag not cleared by write of one");
  chk_cmp_vector: assert property (@(posedge clock) disable iff (rst)
    (compare_vector_ack && !ev_apply[1]) |=> !s.flags[1])
    else $error("compare flag not cleared by vector");
  chk_read_flags: assert property (@(posedge clock) disable iff (rst)
    (s_axi_arvalid && s.ar_rdy && s_axi_araddr == atp_pkg::OFS_FLAGS)
    |=> (s_axi_rdata == {30'h0, $past(s.flags)}))
    else $error("flag read shows wrong or reserved bits");

  // ----------------------------------------------------------------------
  // Checks: flag setting, clock source and prescaler reset
  // ----------------------------------------------------------------------
  chk_set_wins: assert property (@(posedge clock) disable iff (rst)
    ev_apply[1] |=> s.flags[1])
    else $error("compare event lost to a clear");
  chk_cmp_set: assert property (@(posedge clock) disable iff (rst)
    (!s.async_sel && tick && cnt_step == s.cmp) |=> s.flags[1])
    else $error("compare flag not set on match");
  chk_ovf_set: assert property (@(posedge clock) disable iff (rst)
    (!s.async_sel && tick && !s.updown && s.cnt == atp_pkg::COUNT_TOP)
    |=> (s.flags[0] && s.cnt == atp_pkg::COUNT_BOTTOM))
    else $error("overflow flag not set on wrap");
  chk_bottom_turn: assert property (@(posedge clock) disable iff (rst)
    (!s.async_sel && tick && s.updown && s.dir_down && s.cnt == atp_pkg::COUNT_BOTTOM)
    |=> (s.flags[0] && !s.dir_down))
    else $error("overflow flag not set at bottom turn");
  chk_async_events: assert property (@(posedge clock) disable iff (rst)
    (s.async_sel && !s.evt_p2[0] && !s.flags[0]) |=> !s.flags[0])
    else $error("async overflow event bypassed the synchroniser");
  chk_src_io: assert property (@(posedge clock) disable iff (rst)
    !s.async_sel |-> src_tick)
    else $error("io clock source missed a cycle");
  chk_pin_still: assert property (@(posedge clock) disable iff (rst)
    (s.async_sel && s.pin_s2 == s.pin_s3) |-> !src_tick)
    else $error("async source ticked without a pin edge");
  chk_osc_enable: assert property (@(posedge clock) disable iff (rst)
    crystal_osc_enable == (s.async_sel && !s.ext_sel))
    else $error("oscillator enable does not follow the selects");
  chk_ext_clock: assert property (@(posedge clock) disable iff (rst)
    external_clock_mode == (s.async_sel && s.ext_sel))
    else $error("external clock mode does not follow the selects");
  chk_async_presc: assert property (@(posedge clock) disable iff (rst)
    (s.async_sel && s.psr && src_tick) |=> (s.presc == 10'h000))
    else $error("prescaler not reset on async source edge");
  chk_async_keep: assert property (@(posedge clock) disable iff (rst)
    (s.async_sel && s.psr && !s.ack_p2) |=> s.psr)
    else $error("async reset request cleared before acknowledge");
  chk_async_clear: assert property (@(posedge clock) disable iff (rst)
    (s.async_sel && s.psr && s.ack_p2 && !s.timer_sync_hold && !psr_wr_one) |=> !s.psr)
    else $error("async reset request not cleared after acknowledge");

endmodule

`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the timer flag, clock select and prescaler block.
// Assumes the register map and field positions of atp_pkg and one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clock, rst, gie, cva, ova, xtal, xrun, osc_en, ext_md, cmp_irq, ovf_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, c0;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int n_mismatch, total_checks, cyc, xcnt;
  int divs [7] = '{1, 8, 32, 64, 128, 256, 1024};

  atp_timer u_atp_timer (
    .clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .global_irq_enable(gie),
    .compare_vector_ack(cva), .overflow_vector_ack(ova), .compare_irq(cmp_irq),
    .overflow_irq(ovf_irq), .crystal_input_pin(xtal), .crystal_osc_enable(osc_en),
    .external_clock_mode(ext_md)
  );

  // ----------------------------------------------------------------------
  // Clock, crystal pin and timeout
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // The crystal pin toggles every 8 clocks while running and stands still otherwise.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    xcnt <= (xcnt == 7) ? 0 : xcnt + 1;
    if (xrun && xcnt == 7) xtal <= ~xtal;
    if (cyc == 60000) begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge clock);
      if (!aw_d && s_axi_awready === 1'b1) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && s_axi_wready === 1'b1) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  // Lets the counter run undivided for n cycles, then stops it.
  task automatic run(input int n);
    wr(atp_pkg::OFS_CLKSEL, {29'h0, atp_pkg::CS_DIV1});
    repeat (n) @(posedge clock);
    wr(atp_pkg::OFS_CLKSEL, {29'h0, atp_pkg::CS_STOP});
  endtask

  task automatic pulse(input logic which);
    if (which) cva <= 1'b1;
    else ova <= 1'b1;
    @(posedge clock);
    cva <= 1'b0;
    ova <= 1'b0;
    @(posedge clock);
  endtask

  // Counts ticks between two counter reads taken w + 2 cycles apart, one tick of slack.
  task automatic delta(input int w, input int exp, input string what);
    rdr(atp_pkg::OFS_COUNT);
    c0 = rd;
    repeat (w) @(posedge clock);
    rdr(atp_pkg::OFS_COUNT);
    c0 = {24'h0, rd[7:0] - c0[7:0]};
    check({31'h0, (c0 + 1 >= exp) && (c0 <= exp + 1)}, 32'h1, what);
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst, gie, cva, ova, xtal, xrun, s_axi_awvalid, s_axi_wvalid} = 8'h80;
    {s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = 17'h0;
    // Both response channels stay ready, so no task has to toggle them.
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    xcnt = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdr(atp_pkg::OFS_FLAGS);
    check(rd, 32'h0, "flags reset");
    rdr(atp_pkg::OFS_MASK);
    check(rd, 32'h0, "mask reset");
    rdr(8'h40);
    check({30'h0, rsp}, {30'h0, atp_pkg::RESP_SLVERR}, "unmapped read");
    wr(8'h40, 32'h1);
    check({30'h0, rsp}, {30'h0, atp_pkg::RESP_SLVERR}, "unmapped write");
    $display("Test reset and map done");

    wr(atp_pkg::OFS_CMP, 32'h05);
    run(300);
    rdr(atp_pkg::OFS_FLAGS);
    check(rd, 32'h3, "flags after run");
    wr(atp_pkg::OFS_MASK, 32'h3);
    rdr(atp_pkg::OFS_MASK);
    check(rd, 32'h3, "mask readback");
    s_axi_wstrb <= 4'h0;
    wr(atp_pkg::OFS_MASK, 32'h0);
    s_axi_wstrb <= 4'hF;
    check({30'h0, rsp}, {30'h0, atp_pkg::RESP_OKAY}, "strobe-less write response");
    rdr(atp_pkg::OFS_MASK);
    check(rd, 32'h3, "strobe-less write ignored");
    check({30'h0, cmp_irq, ovf_irq}, 32'h0, "irq without global enable");
    gie <= 1'b1;
    repeat (2) @(posedge clock);
    check({30'h0, cmp_irq, ovf_irq}, 32'h3, "irq with enables");
    wr(atp_pkg::OFS_FLAGS, 32'h2);
    rdr(atp_pkg::OFS_FLAGS);
    check(rd, 32'h1, "compare cleared only");
    check({30'h0, cmp_irq, ovf_irq}, 32'h1, "irq after compare clear");
    wr(atp_pkg::OFS_FLAGS, 32'h1);
    rdr(atp_pkg::OFS_FLAGS);
    check(rd, 32'h0, "overflow cleared");
    check({30'h0, ovf_irq}, 32'h0, "overflow irq gone");
    run(300);
    pulse(1'b1);
    rdr(atp_pkg::OFS_FLAGS);
    check(rd, 32'h1, "compare vector clear");
    pulse(1'b0);
    rdr(atp_pkg::OFS_FLAGS);
    check(rd, 32'h0, "overflow vector clear");
    wr(atp_pkg::OFS_FLAGS, 32'hFF);
    rdr(atp_pkg::OFS_FLAGS);
    check(rd, 32'h0, "reserved flag bits");
    $display("Test flags done");

    wr(atp_pkg::OFS_MODE, 32'h1);
    run(600);
    rdr(atp_pkg::OFS_FLAGS);
    check({31'h0, rd[atp_pkg::BIT_OVF]}, 32'h1, "overflow at bottom turn");
    wr(atp_pkg::OFS_MODE, 32'h0);
    wr(atp_pkg::OFS_FLAGS, 32'h3);
    $display("Test up-down done");

    delta(64, 0, "stopped counter");
    for (int i = 0; i < 7; i++) begin
      wr(atp_pkg::OFS_CLKSEL, i + 1);
      delta(divs[i] * 8 - 2, 8, "divided count");
    end
    wr(atp_pkg::OFS_CLKSEL, 32'h0);
    $display("Test clock select done");

    wr(atp_pkg::OFS_GTC, 32'h2);
    rdr(atp_pkg::OFS_GTC);
    check(rd, 32'h0, "sync reset request clears");
    wr(atp_pkg::OFS_GTC, 32'h82);
    rdr(atp_pkg::OFS_GTC);
    check(rd, 32'h82, "hold keeps request");
    wr(atp_pkg::OFS_GTC, 32'h0);
    $display("Test prescaler reset done");

    wr(atp_pkg::OFS_ASYNC, 32'h1);
    repeat (2) @(posedge clock);
    check({30'h0, osc_en, ext_md}, 32'h2, "oscillator mode");
    wr(atp_pkg::OFS_ASYNC, 32'h3);
    repeat (2) @(posedge clock);
    check({30'h0, osc_en, ext_md}, 32'h1, "external clock mode");
    wr(atp_pkg::OFS_CLKSEL, {29'h0, atp_pkg::CS_DIV1});
    delta(128, 0, "async with still pin");
    wr(atp_pkg::OFS_GTC, 32'h2);
    rdr(atp_pkg::OFS_GTC);
    check(rd, 32'h2, "async request pending");
    xrun <= 1'b1;
    repeat (40) @(posedge clock);
    rdr(atp_pkg::OFS_GTC);
    check(rd, 32'h0, "async request done");
    delta(128, 8, "async pin count");
    xrun <= 1'b0;
    wr(atp_pkg::OFS_ASYNC, 32'h0);
    repeat (2) @(posedge clock);
    check({30'h0, osc_en, ext_md}, 32'h0, "io clock mode");
    $display("Test async done");
    close_out();
  end
endmodule

`default_nettype wire
